/* File: src/sas_pkg.sv */
// constants and types shared by the successive-approximation sequencer
package sas_pkg;

  // ==========================================================
  // widths
  localparam int unsigned RES_W = 8;   // result and trial code width
  localparam int unsigned CH_W  = 3;   // eight analog input channels
  localparam int unsigned IDX_W = 3;   // bit position of the trial bit
  localparam int unsigned CNT_W = 8;   // phase cycle counter width

  // ==========================================================
  // bit positions of the search
  localparam logic [IDX_W-1:0] MSB_POS = 3'h7;
  localparam logic [IDX_W-1:0] LSB_POS = 3'h0;

  // ==========================================================
  // reset values
  localparam logic [RES_W-1:0] APPROX_RST = 8'h00;
  localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
  localparam logic [CH_W-1:0]  CHAN_RST   = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

  // ==========================================================
  // timing: times in ns, counts derived from the clock period
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SAMPLE_TIME_NS = 1000; // least sampling time
  localparam int unsigned SETTLE_TIME_NS = 200;  // least tap settle time
  // least times round up to whole cycles
  localparam int unsigned SAMPLE_CYCLES =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // terminal counts at counter width
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

  // ==========================================================
  // sequencer states, gray along idle-sample-search-latch
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_SEARCH = 2'b11,
    ST_LATCH  = 2'b10
  } sas_state_t;

endpackage

/* File: src/sas_result_reg.sv */
// conversion result holding register with registered read data
module sas_result_reg (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     load,
  input  wire logic [sas_pkg::RES_W-1:0] din,
  output logic      [sas_pkg::RES_W-1:0] dout
);
  import sas_pkg::*;

  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] result_nxt;

  // ==========================================================
  // reload on every finished conversion, hold otherwise
  always_comb begin
    result_nxt = result_r;
    if (load) begin
      result_nxt = din;
    end
  end

  // cleared at reset only so the port never floats unknown
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_r <= RESULT_RST;
    end else begin
      result_r <= result_nxt;
    end
  end

  assign dout = result_r;

endmodule

/* File: src/sas_sequencer.sv */
// successive-approximation control for an 8-bit analog-to-digital converter
//
// Functional notes
// - the channel setting is captured as sampling begins.
// - sample for a fixed time, then hold until the result latches.
// - the search opens with bit 7 set, a tap of half the reference.
// - bit 7 stays when the input is at or above half scale, else clears.
// - the next bit is then set, a tap of three or one quarter.
// - a trial bit stays 1 when input >= tap and clears when below.
// - set, compare and decide repeat and end after bit 0.
// - after eight decisions the code is latched and a done pulse raised.
// - the result is an 8-bit register reloaded by each conversion.
// - the result after reset means nothing until a conversion ends.
// - the first result after an enable may be wrong.
// - standby stops all conversion activity at once.
module sas_sequencer (
  input  wire logic                      CLOCK,
  input  wire logic                      RESETN,
  input  wire logic                      CONV_ENABLE,
  input  wire logic [sas_pkg::CH_W-1:0]  CHANNEL_SELECT_REG,
  input  wire logic                      STANDBY,
  input  wire logic                      RESULT_READ,
  input  wire logic                      COMPARATOR_IN,
  output logic      [sas_pkg::CH_W-1:0]  CHANNEL_MUX,
  output logic                           SAMPLE_HOLD,
  output logic      [sas_pkg::RES_W-1:0] TAP_SELECT,
  output logic      [sas_pkg::RES_W-1:0] CONVERSION_RESULT,
  output logic                           CONVERSION_DONE_IRQ,
  output logic                           BUSY,
  output logic                           RESULT_FRESH,
  output logic                           FIRST_RESULT
);
  import sas_pkg::*;

  // ==========================================================
  // declarations
  sas_state_t        state_r;
  sas_state_t        state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  idx_nxt;
  logic [RES_W-1:0]  approx_r;
  logic [RES_W-1:0]  approx_nxt;
  logic [CH_W-1:0]   chan_r;
  logic [CH_W-1:0]   chan_nxt;
  logic              hold_r;
  logic              hold_nxt;
  logic              busy_r;
  logic              busy_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              fresh_r;
  logic              fresh_nxt;
  logic              first_r;
  logic              first_nxt;
  logic              first_pend_r;
  logic              first_pend_nxt;
  logic              comp_meta_r;
  logic              comp_sync_r;
  logic              result_load;
  logic              run_ok;
  logic              sample_done;
  logic              settle_done;

  // ==========================================================
  // comparator crossing
  // the comparator is an analog level with no relation to CLOCK;
  // two flops before anything decides on it
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      comp_meta_r <= COMPARATOR_IN;
      comp_sync_r <= comp_meta_r;
    end
  end

  // ==========================================================
  // phase qualifiers
  // conversion may only proceed when enabled and awake
  assign run_ok      = CONV_ENABLE && !STANDBY;
  assign sample_done = (cnt_r == SAMPLE_LAST);
  // settle count is the tap settle time alone; the two-flop latency falls inside it
  assign settle_done = (cnt_r == SETTLE_LAST);

  // ==========================================================
  // sequencer state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (run_ok) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!run_ok) begin
          state_nxt = ST_IDLE;
        end else if (sample_done) begin
          state_nxt = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (!run_ok) begin
          state_nxt = ST_IDLE;
        end else if (settle_done && idx_r == LSB_POS) begin
          state_nxt = ST_LATCH;
        end
      end
      ST_LATCH: begin
        // back to sampling while enabled, for back-to-back results
        if (run_ok) begin
          state_nxt = ST_SAMPLE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // phase cycle counter
  // restarts on each phase change and after each bit decision
  always_comb begin
    cnt_nxt = CNT_ZERO;
    unique case (state_r)
      ST_SAMPLE: begin
        if (run_ok && !sample_done) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      ST_SEARCH: begin
        if (run_ok && !settle_done) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      ST_IDLE, ST_LATCH: begin
        cnt_nxt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // channel capture
  // taken only when sampling starts, so a later register write
  // cannot switch the input under a running conversion
  always_comb begin
    chan_nxt = chan_r;
    if ((state_r == ST_IDLE || state_r == ST_LATCH) && run_ok) begin
      chan_nxt = CHANNEL_SELECT_REG;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      chan_r <= CHAN_RST;
    end else begin
      chan_r <= chan_nxt;
    end
  end

  // ==========================================================
  // approximation register and bit index
  always_comb begin
    approx_nxt = approx_r;
    idx_nxt    = idx_r;
    unique case (state_r)
      ST_SAMPLE: begin
        if (run_ok && sample_done) begin
          approx_nxt = 8'h80;
          idx_nxt    = MSB_POS;
        end
      end
      ST_SEARCH: begin
        if (run_ok && settle_done) begin
          // one comparator sample per bit step
          if (!comp_sync_r) begin
            approx_nxt[idx_r] = 1'b0;
          end
          if (idx_r != LSB_POS) begin
            // earlier bits stay as decided, so the tap follows them
            approx_nxt[idx_r - 3'h1] = 1'b1;
            idx_nxt = idx_r - 3'h1;
          end
        end
      end
      ST_IDLE, ST_LATCH: begin
        approx_nxt = approx_r;
        idx_nxt    = idx_r;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      approx_r <= APPROX_RST;
      idx_r    <= MSB_POS;
    end else begin
      approx_r <= approx_nxt;
      idx_r    <= idx_nxt;
    end
  end

  // ==========================================================
  // sample-and-hold, busy and done pulse
  always_comb begin
    hold_nxt = 1'b0;
    busy_nxt = 1'b0;
    irq_nxt  = 1'b0;
    unique case (state_nxt)
      ST_IDLE: begin
        hold_nxt = 1'b0;
      end
      ST_SAMPLE: begin
        busy_nxt = 1'b1;
      end
      ST_SEARCH: begin
        hold_nxt = 1'b1;
        busy_nxt = 1'b1;
      end
      ST_LATCH: begin
        // hold is released only once the result is safely latched
        hold_nxt = 1'b1;
        busy_nxt = 1'b1;
        irq_nxt  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      hold_r <= 1'b0;
      busy_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      busy_r <= busy_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // ==========================================================
  // result transfer
  // the load fires in the same cycle the done pulse is raised
  assign result_load = (state_r == ST_LATCH);

  sas_result_reg u_result (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .load  (result_load),
    .din   (approx_r),
    .dout  (CONVERSION_RESULT)
  );

  // ==========================================================
  // result status flags
  // fresh: set by a latch, cleared by a read; a latch in the
  // same cycle as the read wins, so no result goes unseen
  // first: marks the first result after enabling, which may be
  // wrong because the input path had no time to settle
  always_comb begin
    fresh_nxt      = fresh_r;
    first_nxt      = first_r;
    first_pend_nxt = first_pend_r;
    if (RESULT_READ) begin
      fresh_nxt = 1'b0;
    end
    if (state_r == ST_IDLE && run_ok) begin
      first_pend_nxt = 1'b1;
    end
    if (result_load) begin
      fresh_nxt      = 1'b1;
      first_nxt      = first_pend_r;
      first_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      fresh_r      <= 1'b0;
      first_r      <= 1'b0;
      first_pend_r <= 1'b0;
    end else begin
      fresh_r      <= fresh_nxt;
      first_r      <= first_nxt;
      first_pend_r <= first_pend_nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign CHANNEL_MUX         = chan_r;
  assign SAMPLE_HOLD         = hold_r;
  assign TAP_SELECT          = approx_r;
  assign CONVERSION_DONE_IRQ = irq_r;
  assign BUSY                = busy_r;
  assign RESULT_FRESH        = fresh_r;
  assign FIRST_RESULT        = first_r;

endmodule

/* File: verif/sas_analog_model.sv */
// behavioural sample-hold, tap string and comparator
module sas_analog_model
  import sas_pkg::*;
(
  input  wire logic [7:0][RES_W-1:0] levels,
  input  wire logic                  slow,
  input  wire logic [CH_W-1:0]       chan,
  input  wire logic                  hold,
  input  wire logic [RES_W-1:0]      tap,
  output logic                       comp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RES_W-1:0] held;
  // track while sampling, freeze once hold is asserted
  always @(hold or chan or levels) begin
    if (!hold) begin
      held = levels[chan];
    end
  end
  // slow mode settles late but still inside the stable part of a step
  always @(held or tap or slow) begin
    comp <= #(slow ? 60 : 2) (held >= tap);
  end
endmodule

/* File: verif/sas_sequencer_asserts.sv */
// port-level checks of the successive-approximation sequencer
module sas_sequencer_chk
  import sas_pkg::*;
(
  input wire logic             CLOCK,
  input wire logic             RESETN,
  input wire logic             CONV_ENABLE,
  input wire logic [CH_W-1:0]  CHANNEL_SELECT_REG,
  input wire logic             STANDBY,
  input wire logic             RESULT_READ,
  input wire logic             COMPARATOR_IN,
  input wire logic [CH_W-1:0]  CHANNEL_MUX,
  input wire logic             SAMPLE_HOLD,
  input wire logic [RES_W-1:0] TAP_SELECT,
  input wire logic [RES_W-1:0] CONVERSION_RESULT,
  input wire logic             CONVERSION_DONE_IRQ,
  input wire logic             BUSY,
  input wire logic             RESULT_FRESH
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper: cycles spent tracking since the sample phase opened
  logic [CNT_W-1:0] trk_cnt_r;
  logic [CNT_W-1:0] trk_cnt_nxt;
  always_comb begin
    trk_cnt_nxt = (BUSY && !SAMPLE_HOLD) ? trk_cnt_r + 8'h01 : CNT_ZERO;
  end
  always_ff @(posedge CLOCK) begin
    trk_cnt_r <= RESETN ? trk_cnt_nxt : CNT_ZERO;
  end

  // trial step: keep or drop the lowest set bit, then set the next one
  function automatic logic [RES_W-1:0] nxt_tap(logic [RES_W-1:0] p,
                                               logic c);
    logic [RES_W-1:0] lb;
    lb = p & (~p + 8'h01);
    return (c ? p : p & ~lb) | (lb >> 1);
  endfunction

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // ==========================================================
  // properties
  property p_busy_start;
    !BUSY && CONV_ENABLE && !STANDBY |=> BUSY;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy did not follow the enable");
  property p_start_track;
    $rose(BUSY) |-> !SAMPLE_HOLD && CHANNEL_MUX == $past(CHANNEL_SELECT_REG);
  endproperty
  a_start_track: assert property (p_start_track)
    else $error("wrong channel or not tracking at start");
  property p_sample_len;
    $rose(SAMPLE_HOLD) |-> trk_cnt_r == CNT_W'(SAMPLE_CYCLES);
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample phase length wrong");
  property p_first_tap;
    $rose(SAMPLE_HOLD) |-> TAP_SELECT == 8'h80;
  endproperty
  a_first_tap: assert property (p_first_tap)
    else $error("search did not open at half scale");
  property p_decide;
    SAMPLE_HOLD && $past(SAMPLE_HOLD) && $changed(TAP_SELECT) |->
      TAP_SELECT == nxt_tap($past(TAP_SELECT), $past(COMPARATOR_IN, 3));
  endproperty
  a_decide: assert property (p_decide)
    else $error("trial bit decided wrongly");
  property p_step_gap;
    SAMPLE_HOLD && $past(SAMPLE_HOLD) && $changed(TAP_SELECT) |->
      $past(TAP_SELECT, 5) == $past(TAP_SELECT) && $past(SAMPLE_HOLD, 5);
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("bit step spacing wrong");
  property p_done_latch;
    CONVERSION_DONE_IRQ |=> CONVERSION_RESULT == $past(TAP_SELECT) &&
      RESULT_FRESH && !CONVERSION_DONE_IRQ;
  endproperty
  a_done_latch: assert property (p_done_latch)
    else $error("result not latched after done");
  property p_halt;
    STANDBY |=> !BUSY && !SAMPLE_HOLD && !CONVERSION_DONE_IRQ;
  endproperty
  a_halt: assert property (p_halt)
    else $error("activity during standby");

  // main scenarios reached
  c_done: cover property (CONVERSION_DONE_IRQ);
  c_abort: cover property (BUSY && STANDBY);
  c_read: cover property (RESULT_READ && RESULT_FRESH);
endmodule

bind sas_sequencer sas_sequencer_chk i_sas_sequencer_chk (
  .CLOCK, .RESETN, .CONV_ENABLE, .CHANNEL_SELECT_REG, .STANDBY,
  .RESULT_READ, .COMPARATOR_IN, .CHANNEL_MUX, .SAMPLE_HOLD, .TAP_SELECT,
  .CONVERSION_RESULT, .CONVERSION_DONE_IRQ, .BUSY, .RESULT_FRESH
);

/* File: verif/tb.sv */
// self-checking bench for the successive-approximation sequencer
`define CHECK_EQ(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sas_pkg::*;
  logic                  clock = 1'b0;
  logic                  resetn = 1'b0, conv_enable = 1'b0, standby = 1'b0;
  logic                  result_read = 1'b0, slow = 1'b0;
  logic                  comp, sample_hold, irq, busy, fresh, first;
  logic [CH_W-1:0]       chan_sel = CHAN_RST;
  logic [CH_W-1:0]       chan_mux;
  logic [RES_W-1:0]      tap, result;
  logic [7:0][RES_W-1:0] levels = '0;
  logic [RES_W:0]        exp_q[$];
  int                    errors = 0, comparisons = 0, done_seen = 0;

  always #20 clock = ~clock;

  sas_sequencer i_sas_sequencer (
    .CLOCK(clock), .RESETN(resetn), .CONV_ENABLE(conv_enable),
    .CHANNEL_SELECT_REG(chan_sel), .STANDBY(standby),
    .RESULT_READ(result_read), .COMPARATOR_IN(comp),
    .CHANNEL_MUX(chan_mux), .SAMPLE_HOLD(sample_hold), .TAP_SELECT(tap),
    .CONVERSION_RESULT(result), .CONVERSION_DONE_IRQ(irq), .BUSY(busy),
    .RESULT_FRESH(fresh), .FIRST_RESULT(first)
  );
  sas_analog_model i_sas_analog_model (
    .levels(levels), .slow(slow), .chan(chan_mux), .hold(sample_hold),
    .tap(tap), .comp(comp)
  );

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // bounded wait for the monitor to count done pulses
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (done_seen < n && k < 300 * n) begin
      @(negedge clock);
      k++;
    end
    if (done_seen < n) begin
      errors++;
      $display("ERROR done_count expected %0d seen %0d", n, done_seen);
      test_done();
    end
  endtask

  // n back-to-back conversions, then abort the next one mid-sample
  task automatic run(input logic [CH_W-1:0] ch, input int n);
    int base;
    base = done_seen;
    chan_sel = ch;
    slow = 1'($urandom);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({i == 0, levels[ch]});
    end
    conv_enable = 1'b1;
    wait_done(base + n);
    repeat (10) @(negedge clock);
    conv_enable = 1'b0;
    repeat (3) @(negedge clock);
    `CHECK_EQ("busy_off", 1'b0, busy)
  endtask

  // monitor: each done pulse takes the oldest note and checks the result unless it is marked first
  initial begin
    logic [RES_W:0] e;
    forever begin
      @(negedge clock);
      if (irq === 1'b1) begin
        done_seen++;
        // a random read may meet the latch edge; the latch must win
        result_read = 1'($urandom);
        @(negedge clock);
        if (exp_q.size() == 0) begin
          errors++;
          $display("ERROR irq expected none seen 1");
        end else begin
          e = exp_q.pop_front();
          `CHECK_EQ("first", e[RES_W], first)
          if (!e[RES_W]) `CHECK_EQ("result", e[RES_W-1:0], result)
          `CHECK_EQ("fresh", 1'b1, fresh)
        end
        result_read = 1'b1;
        @(negedge clock);
        result_read = 1'b0;
        @(negedge clock);
        `CHECK_EQ("fresh_clr", 1'b0, fresh)
      end
    end
  end

  // watchdog: a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    void'($urandom(92));
    for (int c = 4; c < 8; c++) begin
      levels[c] = 8'($urandom);
    end
    levels[0] = 8'h00;
    levels[1] = 8'hFF;
    levels[2] = 8'h80;
    levels[3] = 8'h7F;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    `CHECK_EQ("busy_rst", 1'b0, busy)
    // every channel, boundary codes first
    for (int c = 0; c < 8; c++) begin
      run(3'(c), 2);
    end
    // standby in mid-search: halt, no done, result kept
    chan_sel = 3'h2;
    conv_enable = 1'b1;
    repeat (40) @(negedge clock);
    standby = 1'b1;
    repeat (2) @(negedge clock);
    `CHECK_EQ("busy_stby", 1'b0, busy)
    `CHECK_EQ("hold_stby", 1'b0, sample_hold)
    repeat (80) @(negedge clock);
    `CHECK_EQ("result_stby", levels[7], result)
    conv_enable = 1'b0;
    standby = 1'b0;
    repeat (4) @(negedge clock);
    levels[5] = 8'($urandom);
    run(3'h5, 3);
    test_done();
  end
endmodule
